// ===== pkg/nvrcs_consts.svh
// Offsets, bit positions, reset values and sizes of the NVM, regulation
// and input comparator status bank; included by the package and the modules.
`ifndef NVRCS_CONSTS_SVH
`define NVRCS_CONSTS_SVH

// ********************************
// Register offsets
// ********************************
`define NVRCS_ADDR_NVM      8'h00
`define NVRCS_ADDR_REG      8'h01
`define NVRCS_ADDR_IVM      8'h02

// ********************************
// Memory status fields
// ********************************
`define NVRCS_NVM_FAIL      5
`define NVRCS_NVM_BUSY      4
`define NVRCS_NVM_CALOK     3
`define NVRCS_NVM_CALF      2
`define NVRCS_NVM_CONFOK    1
`define NVRCS_NVM_CONFF     0

// ********************************
// Regulation status fields
// ********************************
`define NVRCS_REG_VLOOP     1
`define NVRCS_REG_ILOOP     0

// ********************************
// Input comparator fields
// ********************************
`define NVRCS_IVM_LDLIVE    13
`define NVRCS_IVM_LDRISE    11
`define NVRCS_IVM_LDFALL    10
`define NVRCS_IVM_OVLIVE    5
`define NVRCS_IVM_UVLIVE    4
`define NVRCS_IVM_OVRISE    3
`define NVRCS_IVM_OVFALL    2
`define NVRCS_IVM_UVRISE    1
`define NVRCS_IVM_UVFALL    0

// ********************************
// Sizes and reset values
// ********************************
`define NVRCS_FLAG_CNT      5
`define NVRCS_COMP_CNT      11
`define NVRCS_WORD_RST      16'h0000
`define NVRCS_FLAG_RST      5'h00

`endif

// ===== pkg/nvrcs_pkg.sv
// Types shared by the status bank modules.
// Assumes nvrcs_consts.svh is on the include path.
`include "nvrcs_consts.svh"

package nvrcs_pkg;
   typedef logic [7:0]                  nvrcs_addr_t;
   typedef logic [15:0]                 nvrcs_word_t;
   typedef logic [`NVRCS_FLAG_CNT-1:0]  nvrcs_flag_t;
   typedef logic [`NVRCS_COMP_CNT-1:0]  nvrcs_comp_t;
endpackage

// ===== src/nvrcs_sync.sv
// Two-stage synchroniser for the analog comparator and loop levels.
// Assumes inputs are asynchronous levels; no pulse capture is intended.
`timescale 1ns/1ps
`include "nvrcs_consts.svh"

module nvrcs_sync
   import nvrcs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire nvrcs_comp_t rawIn,
   output nvrcs_comp_t      syncOut
);
   nvrcs_comp_t stage1;

   genvar i;
   generate
      for (i = 0; i < `NVRCS_COMP_CNT; i++)
      begin : g_bit
         always_ff @(posedge clk)
         begin
            if (!rstn)
            begin
               stage1[i]  <= 1'b0;
               syncOut[i] <= 1'b0;
            end
            else
            begin
               stage1[i]  <= rawIn[i];
               syncOut[i] <= stage1[i];
            end
         end
      end
   endgenerate
endmodule // nvrcs_sync

// ===== src/nvrcs_flags.sv
// Sticky status flags: set by a hardware pulse, cleared by a write of one.
// Assumes set pulses come from logic on clk.
`timescale 1ns/1ps
`include "nvrcs_consts.svh"

module nvrcs_flags
   import nvrcs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire nvrcs_flag_t setPulse,
   input  wire nvrcs_flag_t clearMask,
   output nvrcs_flag_t      flags
);
   genvar i;
   generate
      for (i = 0; i < `NVRCS_FLAG_CNT; i++)
      begin : g_flag
         always_ff @(posedge clk)
         begin
            if (!rstn)
               flags[i] <= 1'b0;
            // Set beats clear so no event is lost
            else if (setPulse[i])
               flags[i] <= 1'b1;
            else if (clearMask[i])
               flags[i] <= 1'b0;
         end
      end
   endgenerate
endmodule // nvrcs_flags

// ===== src/nvrcs_top.sv
// NVM status, regulation status and input comparator status bank.
// Assumes register access comes from the device's serial interface logic on clk;
// comparator and loop levels arrive asynchronously from the analog side.
//
// Behaviour
// - Memory-failure flag, bit 5, is one when the memory is faulty.
// - Memory-busy, bit 4, is one while the memory is occupied.
// - Calibration-check-passed, bit 3, is one when the calibration CRC matches.
// - Calibration-check-failed, bit 2, is one when the calibration CRC is wrong.
// - Configuration-check-passed, bit 1, is one when the configuration CRC is correct.
// - Configuration-check-failed, bit 0, is one when the configuration CRC is wrong.
// - Every unimplemented bit of these registers reads zero.
// - Regulation bit 1 is one while the voltage loop is closed.
// - Regulation bit 0 is one while the current loop is closed.
// - Comparator bit 13 shows live load dump detection.
// - Bit 11 mirrors the load dump rising comparator.
// - Bit 10 mirrors the load dump falling comparator.
// - Bit 5 shows live input overvoltage detection.
// - Bit 4 shows live input undervoltage detection.
// - Bit 3 mirrors the overvoltage rising comparator.
// - Bit 2 mirrors the overvoltage falling comparator.
// - Hardware sets memory flags; writing one clears, writing zero keeps.
// - Bits 1 and 0 mirror the undervoltage rising and falling comparators.
`timescale 1ns/1ps
`include "nvrcs_consts.svh"

module nvrcs_top
   import nvrcs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire nvrcs_addr_t regAddr,
   input  wire logic        regWrite,
   input  wire nvrcs_word_t regWdata,
   input  wire logic        regRead,
   output nvrcs_word_t      regRdata,
   output logic             regRvalid,
   input  wire logic        memFailEvt,
   input  wire logic        memBusy,
   input  wire logic        calCrcOkEvt,
   input  wire logic        calCrcFailEvt,
   input  wire logic        confCrcOkEvt,
   input  wire logic        confCrcFailEvt,
   input  wire logic        voltageLoopIn,
   input  wire logic        currentLoopIn,
   input  wire logic        loadDumpLiveIn,
   input  wire logic        loadDumpRiseIn,
   input  wire logic        loadDumpFallIn,
   input  wire logic        overLiveIn,
   input  wire logic        underLiveIn,
   input  wire logic        overRiseIn,
   input  wire logic        overFallIn,
   input  wire logic        underRiseIn,
   input  wire logic        underFallIn
);

   // ********************************
   // Analog levels into the clock domain
   // ********************************
   nvrcs_comp_t rawComp;
   nvrcs_comp_t comp;

   assign rawComp = {voltageLoopIn, currentLoopIn, loadDumpLiveIn, loadDumpRiseIn,
                     loadDumpFallIn, overLiveIn, underLiveIn, overRiseIn,
                     overFallIn, underRiseIn, underFallIn};

   // Plain levels, no latching: a glitch shorter than a clock may be missed
   nvrcs_sync u_sync
   (
      .clk     (clk),
      .rstn    (rstn),
      .rawIn   (rawComp),
      .syncOut (comp)
   );

   logic voltageLoopClosed;
   logic currentLoopClosed;
   logic liveLoadDump;
   logic loadDumpRiseMirror;
   logic loadDumpFallMirror;
   logic liveInputOvervoltage;
   logic liveInputUndervoltage;
   logic inputOverRiseMirror;
   logic inputOverFallMirror;
   logic inputUnderRiseMirror;
   logic inputUnderFallMirror;

   assign {voltageLoopClosed, currentLoopClosed, liveLoadDump, loadDumpRiseMirror,
           loadDumpFallMirror, liveInputOvervoltage, liveInputUndervoltage,
           inputOverRiseMirror, inputOverFallMirror, inputUnderRiseMirror,
           inputUnderFallMirror} = comp;

   // ********************************
   // Memory status flags
   // ********************************
   nvrcs_flag_t setPulse;
   nvrcs_flag_t clearMask;
   nvrcs_flag_t memFlags;
   logic        nvmWrite;

   assign nvmWrite  = regWrite && (regAddr == `NVRCS_ADDR_NVM);
   assign setPulse  = {memFailEvt, calCrcOkEvt, calCrcFailEvt, confCrcOkEvt,
                       confCrcFailEvt};
   // Busy is skipped: it is live state and cannot be cleared
   assign clearMask = nvmWrite ? {regWdata[`NVRCS_NVM_FAIL], regWdata[`NVRCS_NVM_CALOK],
                                  regWdata[`NVRCS_NVM_CALF], regWdata[`NVRCS_NVM_CONFOK],
                                  regWdata[`NVRCS_NVM_CONFF]}
                               : `NVRCS_FLAG_RST;

   nvrcs_flags u_flags
   (
      .clk       (clk),
      .rstn      (rstn),
      .setPulse  (setPulse),
      .clearMask (clearMask),
      .flags     (memFlags)
   );

   logic memoryFailureFlag;
   logic calibrationCheckPassed;
   logic calibrationCheckFailed;
   logic configurationCheckPassed;
   logic configurationCheckFailed;

   assign {memoryFailureFlag, calibrationCheckPassed, calibrationCheckFailed,
           configurationCheckPassed, configurationCheckFailed} = memFlags;

   // ********************************
   // Register images
   // ********************************
   nvrcs_word_t nvmImage;
   nvrcs_word_t regImage;
   nvrcs_word_t ivmImage;

   always_comb
   begin
      nvmImage                      = `NVRCS_WORD_RST;
      nvmImage[`NVRCS_NVM_FAIL]     = memoryFailureFlag;
      nvmImage[`NVRCS_NVM_BUSY]     = memBusy;
      nvmImage[`NVRCS_NVM_CALOK]    = calibrationCheckPassed;
      nvmImage[`NVRCS_NVM_CALF]     = calibrationCheckFailed;
      nvmImage[`NVRCS_NVM_CONFOK]   = configurationCheckPassed;
      nvmImage[`NVRCS_NVM_CONFF]    = configurationCheckFailed;
   end

   always_comb
   begin
      regImage                      = `NVRCS_WORD_RST;
      regImage[`NVRCS_REG_VLOOP]    = voltageLoopClosed;
      regImage[`NVRCS_REG_ILOOP]    = currentLoopClosed;
   end

   // Comparator image is rebuilt every cycle from the synchronised levels; nothing latches
   always_comb
   begin
      ivmImage                      = `NVRCS_WORD_RST;
      ivmImage[`NVRCS_IVM_LDLIVE]   = liveLoadDump;
      ivmImage[`NVRCS_IVM_LDRISE]   = loadDumpRiseMirror;
      ivmImage[`NVRCS_IVM_LDFALL]   = loadDumpFallMirror;
      ivmImage[`NVRCS_IVM_OVLIVE]   = liveInputOvervoltage;
      ivmImage[`NVRCS_IVM_UVLIVE]   = liveInputUndervoltage;
      ivmImage[`NVRCS_IVM_OVRISE]   = inputOverRiseMirror;
      ivmImage[`NVRCS_IVM_OVFALL]   = inputOverFallMirror;
      ivmImage[`NVRCS_IVM_UVRISE]   = inputUnderRiseMirror;
      ivmImage[`NVRCS_IVM_UVFALL]   = inputUnderFallMirror;
   end

   // ********************************
   // Read port
   // ********************************
   nvrcs_word_t next_regRdata;

   always_comb
   begin
      if (regAddr == `NVRCS_ADDR_NVM)
         next_regRdata = nvmImage;
      else if (regAddr == `NVRCS_ADDR_REG)
         next_regRdata = regImage;
      else if (regAddr == `NVRCS_ADDR_IVM)
         next_regRdata = ivmImage;
      else
         next_regRdata = `NVRCS_WORD_RST;
   end

   // Data holds after a read until the next read
   always_ff @(posedge clk)
   begin
      if (!rstn)
         regRdata <= `NVRCS_WORD_RST;
      else if (regRead)
         regRdata <= next_regRdata;
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         regRvalid <= 1'b0;
      else
         regRvalid <= regRead;
   end

   // ********************************
   // Assertions
   // ********************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   logic        rdNvm;
   logic        rdReg;
   logic        rdIvm;
   logic        rdOther;

   assign rdNvm   = regRead && (regAddr == `NVRCS_ADDR_NVM);
   assign rdReg   = regRead && (regAddr == `NVRCS_ADDR_REG);
   assign rdIvm   = regRead && (regAddr == `NVRCS_ADDR_IVM);
   assign rdOther = regRead && !rdNvm && !rdReg && !rdIvm;

   a_fail_set_read: assert property (
      memFailEvt ##1 !nvmWrite ##1 rdNvm |=> regRdata[`NVRCS_NVM_FAIL])
      else $error("failure flag not seen after its event");

   a_busy_live: assert property (
      rdNvm |=> regRdata[`NVRCS_NVM_BUSY] == $past(memBusy))
      else $error("busy bit does not follow memory busy");

   a_cal_pass_set: assert property (
      calCrcOkEvt |=> calibrationCheckPassed)
      else $error("calibration pass flag not set");

   a_cal_fail_set: assert property (
      calCrcFailEvt |=> calibrationCheckFailed)
      else $error("calibration fail flag not set");

   a_conf_flags_set: assert property (
      (confCrcOkEvt |=> configurationCheckPassed) and
      (confCrcFailEvt |=> configurationCheckFailed))
      else $error("configuration flags not set");

   a_conf_fail_clear: assert property (
      nvmWrite && regWdata[`NVRCS_NVM_CONFF] && !confCrcFailEvt |=> !configurationCheckFailed)
      else $error("configuration fail flag not cleared by write of one");

   a_upper_zero: assert property (
      rdNvm || rdReg |=> regRdata[15:8] == 8'h00 && regRdata[7:6] == 2'h0)
      else $error("unimplemented bits read nonzero");

   a_unmapped_zero: assert property (
      rdOther |=> regRdata == 16'h0000)
      else $error("unmapped address reads nonzero");

   a_vloop_path: assert property (
      rdReg |=> regRdata[`NVRCS_REG_VLOOP] == $past(voltageLoopIn, 3))
      else $error("voltage loop bit does not follow its input");

   a_iloop_path: assert property (
      rdReg |=> regRdata[`NVRCS_REG_ILOOP] == $past(currentLoopIn, 3))
      else $error("current loop bit does not follow its input");

   a_ldump_live: assert property (
      rdIvm |=> regRdata[`NVRCS_IVM_LDLIVE] == $past(loadDumpLiveIn, 3))
      else $error("load dump live bit wrong");

   a_ldump_mirror: assert property (
      rdIvm |=> regRdata[`NVRCS_IVM_LDRISE] == $past(loadDumpRiseIn, 3)
             && regRdata[`NVRCS_IVM_LDFALL] == $past(loadDumpFallIn, 3))
      else $error("load dump mirror bits wrong");

   a_ovuv_live: assert property (
      rdIvm |=> regRdata[`NVRCS_IVM_OVLIVE] == $past(overLiveIn, 3)
             && regRdata[`NVRCS_IVM_UVLIVE] == $past(underLiveIn, 3))
      else $error("over or under live bit wrong");

   a_ov_mirror: assert property (
      rdIvm |=> regRdata[`NVRCS_IVM_OVRISE] == $past(overRiseIn, 3)
             && regRdata[`NVRCS_IVM_OVFALL] == $past(overFallIn, 3))
      else $error("overvoltage mirror bits wrong");

   a_uv_mirror: assert property (
      rdIvm |=> regRdata[`NVRCS_IVM_UVRISE] == $past(underRiseIn, 3)
             && regRdata[`NVRCS_IVM_UVFALL] == $past(underFallIn, 3))
      else $error("undervoltage mirror bits wrong");

   a_set_wins: assert property (
      memFailEvt && nvmWrite && regWdata[`NVRCS_NVM_FAIL] |=> memoryFailureFlag)
      else $error("set lost against a clear");

   a_zero_keeps: assert property (
      memoryFailureFlag && !(nvmWrite && regWdata[`NVRCS_NVM_FAIL]) |=> memoryFailureFlag [*1])
      else $error("failure flag dropped without a clear");

   a_ro_write: assert property (
      regWrite && regAddr != `NVRCS_ADDR_NVM |=> $stable(memFlags) || $past(setPulse) != `NVRCS_FLAG_RST)
      else $error("write elsewhere changed memory flags");

   a_rvalid_pulse: assert property (
      regRead |=> regRvalid ##1 (regRvalid == $past(regRead)))
      else $error("read valid does not track the read strobe");

   c_flag_cleared: cover property (memoryFailureFlag ##1 nvmWrite ##1 !memoryFailureFlag);
   c_read_ivm_load: cover property (rdIvm ##1 regRdata[`NVRCS_IVM_LDLIVE]);
   c_read_reg_both: cover property (rdReg ##1 regRdata[1:0] == 2'h3);
   c_set_and_clear: cover property (calCrcFailEvt && nvmWrite && regWdata[`NVRCS_NVM_CALF]);

endmodule // nvrcs_top

// ===== tb/nvm_regulation_input_comparator_status_tb.sv
// Self-checking bench for the NVM, regulation and input comparator status bank.
// Assumes nvrcs_consts.svh on the include path and nvrcs_pkg compiled first.
`timescale 1ns/1ps
`include "nvrcs_consts.svh"

module nvm_regulation_input_comparator_status_tb
   import nvrcs_pkg::*;
;
   logic        clk;
   logic        rstn;
   nvrcs_addr_t regAddr;
   logic        regWrite;
   nvrcs_word_t regWdata;
   logic        regRead;
   nvrcs_word_t regRdata;
   logic        regRvalid;
   logic [4:0]  evts;
   logic        memBusy;
   logic [1:0]  loops;
   logic [8:0]  ivm;
   int          numErrors;
   int          checksDone;
   int          cycles;

   // Field positions of the event flags and comparator inputs, in vector order
   int          evtPos[5] = '{`NVRCS_NVM_CONFF, `NVRCS_NVM_CONFOK, `NVRCS_NVM_CALF, `NVRCS_NVM_CALOK, `NVRCS_NVM_FAIL};
   int          ivmPos[9] = '{`NVRCS_IVM_UVFALL, `NVRCS_IVM_UVRISE, `NVRCS_IVM_OVFALL, `NVRCS_IVM_OVRISE,
                              `NVRCS_IVM_UVLIVE, `NVRCS_IVM_OVLIVE, `NVRCS_IVM_LDFALL, `NVRCS_IVM_LDRISE,
                              `NVRCS_IVM_LDLIVE};

   nvrcs_top u_dut (
      .clk            (clk),
      .rstn           (rstn),
      .regAddr        (regAddr),
      .regWrite       (regWrite),
      .regWdata       (regWdata),
      .regRead        (regRead),
      .regRdata       (regRdata),
      .regRvalid      (regRvalid),
      .memFailEvt     (evts[4]),
      .memBusy        (memBusy),
      .calCrcOkEvt    (evts[3]),
      .calCrcFailEvt  (evts[2]),
      .confCrcOkEvt   (evts[1]),
      .confCrcFailEvt (evts[0]),
      .voltageLoopIn  (loops[1]),
      .currentLoopIn  (loops[0]),
      .loadDumpLiveIn (ivm[8]),
      .loadDumpRiseIn (ivm[7]),
      .loadDumpFallIn (ivm[6]),
      .overLiveIn     (ivm[5]),
      .underLiveIn    (ivm[4]),
      .overRiseIn     (ivm[3]),
      .overFallIn     (ivm[2]),
      .underRiseIn    (ivm[1]),
      .underFallIn    (ivm[0])
   );

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ********************************
   // Shared tasks
   // ********************************
   task automatic results();
      $display("Comparisons: %0d  mismatches: %0d", checksDone, numErrors);
      if (numErrors == 0 && checksDone > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic checkWord(input nvrcs_word_t got, input nvrcs_word_t exp, input string what);
      checksDone++;
      if (got !== exp)
      begin
         numErrors++;
         $display("ERROR t=%0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic checkBit(input logic got, input logic exp, input string what);
      checksDone++;
      if (got !== exp)
      begin
         numErrors++;
         $display("ERROR t=%0t %s: got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic readCheck(input nvrcs_addr_t addr, input nvrcs_word_t exp);
      @(negedge clk);
      regRead = 1'b1;
      regAddr = addr;
      @(negedge clk);
      regRead = 1'b0;
      checkBit(regRvalid, 1'b1, "read valid");
      checkWord(regRdata, exp, $sformatf("read of index %h", addr));
      // Valid is a one-cycle pulse; data must stand until the next read
      @(negedge clk);
      checkBit(regRvalid, 1'b0, "read valid pulse");
      checkWord(regRdata, exp, "read data hold");
   endtask

   task automatic writeReg(input nvrcs_addr_t addr, input nvrcs_word_t data);
      @(negedge clk);
      regWrite = 1'b1;
      regAddr  = addr;
      regWdata = data;
      @(negedge clk);
      regWrite = 1'b0;
   endtask

   // Asynchronous levels need the two-flop delay before a read sees them
   task automatic settle();
      repeat (3) @(negedge clk);
   endtask

   // ********************************
   // Scenarios
   // ********************************
   task automatic testReset();
      checkWord(regRdata, 16'h0000, "read data after reset");
      checkBit(regRvalid, 1'b0, "read valid after reset");
      readCheck(`NVRCS_ADDR_NVM, 16'h0000);
      readCheck(`NVRCS_ADDR_REG, 16'h0000);
      readCheck(`NVRCS_ADDR_IVM, 16'h0000);
      readCheck(8'h7f, 16'h0000);
   endtask

   task automatic testEventFlags();
      nvrcs_word_t exp;
      for (int i = 0; i < 5; i++)
      begin
         exp = 16'h0001 << evtPos[i];
         @(negedge clk);
         evts[i] = 1'b1;
         @(negedge clk);
         evts[i] = 1'b0;
         readCheck(`NVRCS_ADDR_NVM, exp);
         writeReg(`NVRCS_ADDR_NVM, ~exp);
         readCheck(`NVRCS_ADDR_NVM, exp);
         writeReg(`NVRCS_ADDR_NVM, 16'h0000);
         readCheck(`NVRCS_ADDR_NVM, exp);
         writeReg(`NVRCS_ADDR_NVM, exp);
         readCheck(`NVRCS_ADDR_NVM, 16'h0000);
      end
   endtask

   // A clear landing with a new event must not lose the event
   task automatic testSetBeatsClear();
      @(negedge clk);
      evts[4]  = 1'b1;
      regWrite = 1'b1;
      regAddr  = `NVRCS_ADDR_NVM;
      regWdata = 16'h0020;
      @(negedge clk);
      evts[4]  = 1'b0;
      regWrite = 1'b0;
      readCheck(`NVRCS_ADDR_NVM, 16'h0020);
      writeReg(`NVRCS_ADDR_NVM, 16'hffff);
      readCheck(`NVRCS_ADDR_NVM, 16'h0000);
   endtask

   task automatic testBusy();
      @(negedge clk);
      memBusy = 1'b1;
      readCheck(`NVRCS_ADDR_NVM, 16'h0010);
      writeReg(`NVRCS_ADDR_NVM, 16'hffff);
      readCheck(`NVRCS_ADDR_NVM, 16'h0010);
      @(negedge clk);
      memBusy = 1'b0;
      readCheck(`NVRCS_ADDR_NVM, 16'h0000);
   endtask

   task automatic testRegulation();
      for (int i = 0; i < 4; i++)
      begin
         @(negedge clk);
         loops = i[1:0];
         settle();
         readCheck(`NVRCS_ADDR_REG, {14'h0000, i[1:0]});
      end
      writeReg(`NVRCS_ADDR_REG, 16'h0000);
      readCheck(`NVRCS_ADDR_REG, 16'h0003);
      @(negedge clk);
      loops = 2'b00;
      settle();
      readCheck(`NVRCS_ADDR_REG, 16'h0000);
   endtask

   task automatic testComparators();
      for (int i = 0; i < 9; i++)
      begin
         @(negedge clk);
         ivm = 9'h001 << i;
         settle();
         readCheck(`NVRCS_ADDR_IVM, 16'h0001 << ivmPos[i]);
      end
      @(negedge clk);
      ivm = 9'h1ff;
      settle();
      readCheck(`NVRCS_ADDR_IVM, 16'h2c3f);
      readCheck(8'h03, 16'h0000);
      writeReg(`NVRCS_ADDR_IVM, 16'h0000);
      readCheck(`NVRCS_ADDR_IVM, 16'h2c3f);
      readCheck(`NVRCS_ADDR_NVM, 16'h0000);
      @(negedge clk);
      ivm = 9'h000;
      settle();
      readCheck(`NVRCS_ADDR_IVM, 16'h0000);
   endtask

   // ********************************
   // Main sequence and hang guard
   // ********************************
   initial
   begin
      numErrors  = 0;
      checksDone = 0;
      rstn       = 1'b0;
      regAddr    = 8'h00;
      regWrite   = 1'b0;
      regWdata   = 16'h0000;
      regRead    = 1'b0;
      evts       = 5'h00;
      memBusy    = 1'b0;
      loops      = 2'b00;
      ivm        = 9'h000;
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      testReset();
      testEventFlags();
      testSetBeatsClear();
      testBusy();
      testRegulation();
      testComparators();
      results();
   end

   // Whole run needs well under a thousand cycles
   initial
   begin
      cycles = 0;
      while (cycles < 5000)
      begin
         @(posedge clk);
         cycles++;
      end
      numErrors++;
      $display("ERROR t=%0t run did not finish in time", $time);
      results();
   end
endmodule // nvm_regulation_input_comparator_status_tb
